// *** bench/lse_status_bank_test.sv ***
// testbench: lane error counters, alignment status flags and interrupt of the status bank
`timescale 1ns/1ns
`default_nettype none
module lse_status_bank_test
  import lse_pkg::*;
;
  logic        clk_sys, sys_rst, reg_wr, reg_rd, irq, align_fifo_fault, align_live, rd_pend;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, lane_tp_errs;
  logic [3:0]  lane_bad_word, lane_los, lane_sync, lane_dec;
  int          n_errors, n_tests, seed, cyc, e[4];
  logic [15:0] exp_q[$];
  logic [3:0]  bw;
  logic [15:0] tp;

  lse_status_bank i_lse_status_bank (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lane_bad_word(lane_bad_word),
    .lane_tp_errs(lane_tp_errs), .lane_signal_absent(lane_los),
    .slave_channel_synced(lane_sync), .slave_bad_decode(lane_dec),
    .align_fifo_fault(align_fifo_fault), .master_align_sequence_active(align_live), .irq(irq));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // read data stand only in the cycle after the strobe, so look mid-cycle
  always @(posedge clk_sys) rd_pend <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) chk("unexpected read", reg_rdata, 16'h0000);
      else chk("read data", reg_rdata, exp_q.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(exp);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // random errors for n cycles; expectation follows the mode in force
  task automatic errs(input int n, input bit tpm);
    for (int c = 0; c < n; c++) begin
      @(posedge clk_sys);
      bw = 4'($random(seed));
      tp = 16'($random(seed));
      lane_bad_word <= bw;
      lane_tp_errs <= tp;
      for (int l = 0; l < 4; l++) e[l] += tpm ? int'(tp[4*l +: 4]) : int'(bw[l]);
    end
    @(posedge clk_sys);
    lane_bad_word <= 4'h0;
    lane_tp_errs <= 16'h0000;
  endtask

  initial begin
    seed = 18;
    sys_rst = 1'b1;
    {reg_wr, reg_rd, align_fifo_fault, align_live, rd_pend} = '0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    lane_bad_word = 4'h0;
    lane_tp_errs = 16'h0000;
    {lane_los, lane_dec} = 8'h00;
    lane_sync = 4'hF;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int l = 0; l < 4; l++) rd(LSE_IDX_LANE0 + 8'(l), 16'hFFFD);
    for (int l = 0; l < 4; l++) rd(LSE_IDX_LANE0 + 8'(l), 16'h0000);
    rd(LSE_IDX_STATUS, 16'h0000);
    $display("reset values done");
    e = '{default: 0};
    errs(20, 1'b0);
    wr(LSE_IDX_LANE3, 16'h1234);
    for (int l = 0; l < 4; l++) rd(LSE_IDX_LANE0 + 8'(l), 16'(e[l]));
    rd(LSE_IDX_LANE3, 16'h0000);
    $display("functional counting done");
    // every pattern select code; bad words must be ignored while testing
    for (int ps = 0; ps < 4; ps++) begin
      wr(LSE_IDX_TPCFG, 16'h0001 | 16'(ps << LSE_TP_SEL_LO));
      e = '{default: 0};
      errs(10, 1'b1);
      for (int l = 0; l < 4; l++) rd(LSE_IDX_LANE0 + 8'(l), 16'(e[l]));
    end
    wr(LSE_IDX_TPCFG, 16'h0000);
    $display("test pattern counting done");
    wr(LSE_IDX_IRQ_CL, 16'h000F);
    @(posedge clk_sys);
    align_fifo_fault <= 1'b1;
    // two cycles: the input filter drops one-cycle glitches
    @(posedge clk_sys);
    @(posedge clk_sys);
    align_fifo_fault <= 1'b0;
    idle(6);
    @(negedge clk_sys);
    chk("irq masked", 16'(irq), 16'h0000);
    rd(LSE_IDX_STATUS, 16'h8100);
    rd(LSE_IDX_STATUS, 16'h0100);
    rd(LSE_IDX_IRQ_ST, 16'h0001);
    wr(LSE_IDX_IRQ_EN, 16'h0001);
    idle(1);
    @(negedge clk_sys);
    chk("irq enabled", 16'(irq), 16'h0001);
    wr(LSE_IDX_IRQ_CL, 16'h0001);
    idle(1);
    @(negedge clk_sys);
    chk("irq cleared", 16'(irq), 16'h0000);
    rd(LSE_IDX_IRQ_ST, 16'h0000);
    $display("fifo fault and interrupt done");
    @(posedge clk_sys);
    align_live <= 1'b1;
    idle(6);
    rd(LSE_IDX_STATUS, 16'h0900);
    align_live <= 1'b0;
    idle(6);
    wr(LSE_IDX_CFG, 16'h2000);
    @(posedge clk_sys);
    lane_los <= 4'h2;
    @(posedge clk_sys);
    lane_los <= 4'h4;
    @(posedge clk_sys);
    lane_los <= 4'h0;
    idle(2);
    rd(LSE_IDX_STATUS, 16'h0500);
    wr(LSE_IDX_STATUS, 16'hFFFF);
    rd(LSE_IDX_STATUS, 16'h0100);
    @(posedge clk_sys);
    lane_sync <= 4'hB;
    lane_dec <= 4'h4;
    @(posedge clk_sys);
    @(posedge clk_sys);
    lane_sync <= 4'hF;
    lane_dec <= 4'h0;
    idle(6);
    rd(LSE_IDX_STATUS, 16'h0008);
    rd(LSE_IDX_STATUS, 16'h0100);
    rd(LSE_IDX_IRQ_ST, 16'h000E);
    wr(LSE_IDX_IRQ_CL, 16'h000E);
    rd(LSE_IDX_IRQ_ST, 16'h0000);
    rd(LSE_IDX_LANE2, 16'h0000);
    rd(8'hEE, 16'h0000);
    $display("status flags done");
    idle(3);
    chk("pending reads", 16'(exp_q.size()), 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire

// *** rtl/lse_lane_counter.sv ***
// module: one saturating lane error counter, cleared when read
`timescale 1ns/1ns
`default_nettype none
module lse_lane_counter
  import lse_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // lane
  lse_lane_if.ctr  ln
);
  typedef struct packed {
    logic [15:0] cnt;
  } lse_ctr_t;
  lse_ctr_t st_q;
  lse_ctr_t st_d;
  logic [16:0] sum;
  logic [15:0] add;

  always_comb begin
    add = ln.tp_mode ? {12'h000, ln.tp_errs} : {15'h0000, ln.bad_word};
    sum = {1'b0, st_q.cnt} + {1'b0, add};
    st_d = st_q;
    // saturate rather than wrap so a burst never reads as few errors
    st_d.cnt = sum[16] ? LSE_CNT_MAX : sum[15:0];
    // errors in the read cycle are kept, not lost to the clear
    if (ln.rd_clr) begin
      st_d.cnt = add;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q.cnt <= LSE_CNT_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign ln.count = st_q.cnt;

  a_clear_on_read: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ln.rd_clr |=> (st_q.cnt == $past(add)))
    else $error("counter not cleared by read");
  a_count_func: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (!ln.rd_clr && !ln.tp_mode && ln.bad_word && st_q.cnt < 16'hFFFE)
    |=> st_q.cnt == $past(st_q.cnt) + 16'h0001)
    else $error("bad word not counted");
  a_count_hold: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (!ln.rd_clr && !ln.tp_mode && !ln.bad_word) |=> $stable(st_q.cnt))
    else $error("counter moved without error");
endmodule
`default_nettype wire

// *** rtl/lse_lane_if.sv ***
// interface: one lane counter's inputs and clear-on-read strobe
`timescale 1ns/1ns
`default_nettype none
interface lse_lane_if;
  import lse_pkg::*;
  logic            bad_word;
  logic [3:0]      tp_errs;
  logic            tp_mode;
  logic            rd_clr;
  logic [15:0]     count;
  modport ctr (input bad_word, input tp_errs, input tp_mode, input rd_clr, output count);
  modport top (output bad_word, output tp_errs, output tp_mode, output rd_clr, input count);
endinterface
`default_nettype wire

// *** rtl/lse_pkg.sv ***
// package: register map, field positions and reset values of the lane status bank
package lse_pkg;
  localparam int          LSE_LANES      = 4;
  localparam int          LSE_CW         = 16;
  localparam int          LSE_AW         = 8;
  // register indices; byte address is four times the index
  localparam logic [7:0]  LSE_IDX_LANE0  = 8'h11;
  localparam logic [7:0]  LSE_IDX_LANE1  = 8'h12;
  localparam logic [7:0]  LSE_IDX_LANE2  = 8'h13;
  localparam logic [7:0]  LSE_IDX_LANE3  = 8'h14;
  localparam logic [7:0]  LSE_IDX_STATUS = 8'h15;
  // configuration registers kept locally (lane select, pattern select)
  localparam logic [7:0]  LSE_IDX_CFG    = 8'h0C;
  localparam logic [7:0]  LSE_IDX_TPCFG  = 8'h0B;
  localparam logic [7:0]  LSE_IDX_IRQ_ST = 8'h30;
  localparam logic [7:0]  LSE_IDX_IRQ_EN = 8'h31;
  localparam logic [7:0]  LSE_IDX_IRQ_CL = 8'h32;
  localparam int          LSE_CFG_SEL_LO = 12;
  localparam int          LSE_TP_SEL_LO  = 4;
  localparam int          LSE_TP_EN_BIT  = 0;
  localparam int          LSE_ST_FIFO    = 15;
  localparam int          LSE_ST_ALIGN   = 11;
  localparam int          LSE_ST_LOS     = 10;
  localparam int          LSE_ST_SYNC    = 8;
  localparam int          LSE_ST_DEC     = 3;
  localparam logic [15:0] LSE_CNT_RESET  = 16'hFFFD;
  localparam logic [15:0] LSE_CNT_CLEAR  = 16'h0000;
  localparam logic [15:0] LSE_ST_RESET   = 16'h0000;
  localparam logic [15:0] LSE_CNT_MAX    = 16'hFFFF;
  // interrupt bits: fifo fault, los, sync lost, bad decode
  localparam int          LSE_IRQ_W      = 4;
endpackage

// *** rtl/lse_status_bank.sv ***
// module: low-speed lane error counters and alignment status register bank
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module lse_status_bank
  import lse_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [15:0] reg_rdata,
  // lane alignment slave, per lane except the fifo fault
  input  wire logic [3:0]  lane_bad_word,
  input  wire logic [15:0] lane_tp_errs,
  input  wire logic [3:0]  lane_signal_absent,
  input  wire logic [3:0]  slave_channel_synced,
  input  wire logic [3:0]  slave_bad_decode,
  input  wire logic        align_fifo_fault,
  // lane alignment master
  input  wire logic        master_align_sequence_active,
  // interrupt
  output var  logic        irq
);
  typedef struct packed {
    logic [15:0] rdata;
    logic [1:0]  lane_sel;
    logic [1:0]  tp_sel;
    logic        tp_en;
    logic        fifo_lh;
    logic        los_lh;
    logic        sync_ll;
    logic        dec_lh;
    logic [3:0]  irq_st;
    logic [3:0]  irq_en;
    logic        irq;
    logic [2:0]  ext_s1;
    logic [2:0]  ext_s2;
    logic [2:0]  ext_s3;
    logic [2:0]  ext_f;
  } lse_state_t;

  lse_state_t  st_q;
  lse_state_t  st_d;
  logic [15:0] cnt [LSE_LANES];
  logic [3:0]  rd_clr;
  logic [15:0] status_word;
  logic        sel_los;
  logic        sel_sync;
  logic        sel_dec;
  logic        fifo_now;
  logic        align_now;
  logic [3:0]  ev;
  logic        status_rd;

  // fifo, align and the selected lane flags come from other domains
  assign sel_los  = lane_signal_absent[st_q.lane_sel];
  assign sel_sync = slave_channel_synced[st_q.lane_sel];
  assign sel_dec  = slave_bad_decode[st_q.lane_sel];
  // status read strobe, shared by the flag checks below
  assign status_rd = reg_rd && reg_addr == LSE_IDX_STATUS;

  // counters: lane 0 at 0x11, lanes 1..3 follow
  genvar g;
  for (g = 0; g < LSE_LANES; g++) begin : g_lane
    lse_lane_if lif ();
    assign lif.bad_word = lane_bad_word[g];
    assign lif.tp_errs  = lane_tp_errs[g*4 +: 4];
    assign lif.tp_mode  = st_q.tp_en;
    assign lif.rd_clr   = rd_clr[g];
    assign cnt[g]       = lif.count;
    lse_lane_counter u_ctr (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .ln      (lif)
    );
  end

  always_comb begin
    rd_clr = 4'h0;
    if (reg_rd && reg_addr == LSE_IDX_LANE0) begin
      rd_clr[0] = 1'b1;
    end else if (reg_rd && reg_addr == LSE_IDX_LANE1) begin
      rd_clr[1] = 1'b1;
    end else if (reg_rd && reg_addr == LSE_IDX_LANE2) begin
      rd_clr[2] = 1'b1;
    end else if (reg_rd && reg_addr == LSE_IDX_LANE3) begin
      rd_clr[3] = 1'b1;
    end
  end

  always_comb begin
    fifo_now  = st_q.ext_f[0];
    align_now = st_q.ext_f[1];
    status_word = LSE_ST_RESET;
    status_word[LSE_ST_FIFO]  = st_q.fifo_lh;
    status_word[LSE_ST_ALIGN] = align_now;
    status_word[LSE_ST_LOS]   = st_q.los_lh;
    status_word[LSE_ST_SYNC]  = st_q.sync_ll;
    status_word[LSE_ST_DEC]   = st_q.dec_lh;
  end

  always_comb begin
    st_d = st_q;
    // three-stage synchronisers for the fifo, align and selected lane sync inputs
    st_d.ext_s1 = {sel_sync, master_align_sequence_active, align_fifo_fault};
    st_d.ext_s2 = st_q.ext_s1;
    st_d.ext_s3 = st_q.ext_s2;
    // a change is taken only once stages two and three agree; one-cycle glitches are dropped
    st_d.ext_f  = (st_q.ext_s2 & st_q.ext_s3) | (st_q.ext_f & (st_q.ext_s2 ^ st_q.ext_s3));
    ev = 4'h0;
    // latched flags: a read re-arms them, a live condition wins
    if (reg_rd && reg_addr == LSE_IDX_STATUS) begin
      st_d.fifo_lh = fifo_now;
      st_d.los_lh  = sel_los;
      st_d.sync_ll = st_q.ext_f[2];
      st_d.dec_lh  = sel_dec;
    end else begin
      st_d.fifo_lh = st_q.fifo_lh | fifo_now;
      st_d.los_lh  = st_q.los_lh | sel_los;
      st_d.sync_ll = st_q.sync_ll & st_q.ext_f[2];
      st_d.dec_lh  = st_q.dec_lh | sel_dec;
    end
    ev[0] = fifo_now;
    ev[1] = sel_los;
    ev[2] = st_q.sync_ll & ~st_q.ext_f[2];
    ev[3] = sel_dec;
    // read data, one cycle later
    st_d.rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == LSE_IDX_LANE0) begin
        st_d.rdata = cnt[0];
      end else if (reg_addr == LSE_IDX_LANE1) begin
        st_d.rdata = cnt[1];
      end else if (reg_addr == LSE_IDX_LANE2) begin
        st_d.rdata = cnt[2];
      end else if (reg_addr == LSE_IDX_LANE3) begin
        st_d.rdata = cnt[3];
      end else if (reg_addr == LSE_IDX_STATUS) begin
        st_d.rdata = status_word;
      end else if (reg_addr == LSE_IDX_CFG) begin
        st_d.rdata = {2'b00, st_q.lane_sel, 12'h000};
      end else if (reg_addr == LSE_IDX_TPCFG) begin
        st_d.rdata = {10'h000, st_q.tp_sel, 3'b000, st_q.tp_en};
      end else if (reg_addr == LSE_IDX_IRQ_ST) begin
        st_d.rdata = {12'h000, st_q.irq_st};
      end else if (reg_addr == LSE_IDX_IRQ_EN) begin
        st_d.rdata = {12'h000, st_q.irq_en};
      end
    end
    // writes to the status and counters are ignored
    if (reg_wr) begin
      if (reg_addr == LSE_IDX_CFG) begin
        st_d.lane_sel = reg_wdata[LSE_CFG_SEL_LO +: 2];
      end else if (reg_addr == LSE_IDX_TPCFG) begin
        st_d.tp_sel = reg_wdata[LSE_TP_SEL_LO +: 2];
        st_d.tp_en  = reg_wdata[LSE_TP_EN_BIT];
      end else if (reg_addr == LSE_IDX_IRQ_EN) begin
        st_d.irq_en = reg_wdata[LSE_IRQ_W-1:0];
      end else if (reg_addr == LSE_IDX_IRQ_CL) begin
        st_d.irq_st = st_q.irq_st & ~reg_wdata[LSE_IRQ_W-1:0];
      end
    end
    st_d.irq_st = st_d.irq_st | ev;
    st_d.irq = |(st_d.irq_st & st_d.irq_en);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.sync_ll <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign irq       = st_q.irq;

  // flag, read path and interrupt checks
  a_fifo_latch: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q.fifo_lh && !status_rd) |=> st_q.fifo_lh)
    else $error("fifo fault flag dropped before read");

  a_fifo_set: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    fifo_now |=> st_q.fifo_lh)
    else $error("fifo fault not latched");

  a_los_latch: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    sel_los |=> st_q.los_lh)
    else $error("los flag not latched");

  a_los_hold: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q.los_lh && !status_rd) |=> st_q.los_lh)
    else $error("los flag dropped before read");

  a_los_rearm: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (status_rd && !sel_los) |=> !st_q.los_lh)
    else $error("los flag not re-armed by read");

  a_sync_low: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (!st_q.sync_ll && !status_rd) |=> !st_q.sync_ll)
    else $error("sync flag rose without read");

  a_sync_fall: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !st_q.ext_f[2] |=> !st_q.sync_ll)
    else $error("sync loss not latched");

  a_sync_rearm: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (status_rd && st_q.ext_f[2]) |=> st_q.sync_ll)
    else $error("sync flag not re-armed by read");

  a_dec_latch: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q.dec_lh && !status_rd) |=> st_q.dec_lh)
    else $error("decode flag dropped before read");

  a_dec_set: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    sel_dec |=> st_q.dec_lh)
    else $error("decode error not latched");

  a_reserved_zero: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    status_rd |=> (reg_rdata & 16'h72F7) == 16'h0000)
    else $error("reserved status bits set");

  a_align_live: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (status_rd && st_q.ext_f[1] == st_q.ext_s3[1])
    |=> reg_rdata[LSE_ST_ALIGN] == $past(st_q.ext_s3[1]))
    else $error("align state bit wrong");

  a_filter_hold: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q.ext_s2[1] != st_q.ext_s3[1]) |=> $stable(st_q.ext_f[1]))
    else $error("align filter moved on disagreement");

  a_lane_select: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && reg_addr == LSE_IDX_CFG) |=> st_q.lane_sel == $past(reg_wdata[13:12]))
    else $error("lane select not written");

  a_lane0_read: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && reg_addr == LSE_IDX_LANE0) |=> reg_rdata == $past(cnt[0]))
    else $error("lane 0 read data wrong");

  a_lane1_read: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && reg_addr == LSE_IDX_LANE1) |=> reg_rdata == $past(cnt[1]))
    else $error("lane 1 read data wrong");

  a_lane2_read: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && reg_addr == LSE_IDX_LANE2) |=> reg_rdata == $past(cnt[2]))
    else $error("lane 2 read data wrong");

  a_cnt_read: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && reg_addr == LSE_IDX_LANE3) |=> reg_rdata == $past(cnt[3]))
    else $error("lane 3 read data wrong");

  a_status_no_write: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && !reg_rd && reg_addr == LSE_IDX_STATUS && !fifo_now) |=> $stable(st_q.fifo_lh))
    else $error("status write changed a flag");

  a_irq_level: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    irq == (|(st_q.irq_st & st_q.irq_en)))
    else $error("interrupt level wrong");

  a_irq_sticky: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    fifo_now |=> st_q.irq_st[0])
    else $error("fifo fault interrupt not set");
endmodule
`default_nettype wire
